// ===== pkg/acc_map.svh
// Register offsets, field positions, reset values and timing counts of the
// conversion control block. Assumes a 32-bit classic Wishbone slave port.
//
// How it works
// - Each finished conversion loads the result high and low bytes, ground referenced.
// - Results are unsigned ten-bit integers from zero to full scale minus one step.
// - Justify zero right-aligns the pair (0x03FF); justify one left-aligns it (0xFFC0).
// - Result bits unused by the current alignment read as zero.
// - Eight-bit mode converts only eight MSBs and places them in the high byte.
// - Eight-bit mode ignores the justify select bit.
// - Ten-bit conversion takes 13 conversion clocks; eight-bit takes 11.
// - Conversion clock is the system clock divided by the configured divider field plus one.
// - A three-bit field picks software, timer 0, 2, 1, external edge, timer 3.
// - In on-demand mode, writing one to busy starts a conversion.
// - Busy stays one during the conversion and clears when it completes.
// - Busy falling sets the done flag and, if enabled, requests an interrupt.
// - Timers 2 and 3 trigger on low-byte overflow in 8-bit, high-byte in 16-bit.
// - External source starts a conversion on each rising edge of the start pin.
// - Inside window flags results strictly between greater-than and less-than bounds.
// - Outside window flags results below greater-than or above less-than bound.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ACC_OFS_CONTROL  8'h00
`define ACC_OFS_CONFIG   8'h04
`define ACC_OFS_RESULT   8'h08
`define ACC_OFS_GT_BOUND 8'h0C
`define ACC_OFS_LT_BOUND 8'h10
`define ACC_OFS_STATUS   8'h14
`define ACC_OFS_MASK     8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ACC_CTL_SRC_LSB  0
`define ACC_CTL_BUSY     3
`define ACC_CTL_T2_16    4
`define ACC_CTL_T3_16    5
`define ACC_CFG_JUSTIFY  0
`define ACC_CFG_EIGHT    1
`define ACC_CFG_DIV_LSB  3
`define ACC_ST_DONE      0
`define ACC_ST_WINDOW    1

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define ACC_DIV_RESET    5'h03
`define ACC_HOLD_TICKS   2'h2
`define ACC_PROBE_TOP    10'h200
`define ACC_STOP_TEN     10'h001
`define ACC_STOP_EIGHT   10'h004

`endif

// ===== pkg/acc_pkg.sv
// Types shared by the conversion control block.
// Assumes the register map header is compiled alongside.
package acc_pkg;

  typedef enum logic [2:0] {
    ACC_SRC_SOFTWARE = 3'h0,
    ACC_SRC_TIMER0   = 3'h1,
    ACC_SRC_TIMER2   = 3'h2,
    ACC_SRC_TIMER1   = 3'h3,
    ACC_SRC_EXTERNAL = 3'h4,
    ACC_SRC_TIMER3   = 3'h5
  } acc_source_t;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_HOLD,
    ACC_BITS,
    ACC_FINISH
  } acc_sar_state_t;

endpackage

// ===== rtl/acc_sync.sv
// Three-stage synchroniser with agreement filter for the external start pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
module acc_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  logic stage1;
  logic stage2;
  logic stage3;

  // The level only moves once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
      rise   <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3;
      end
      rise <= (stage2 == stage3) && stage3 && !level;
    end
  end
endmodule

// ===== rtl/acc_sar.sv
// Successive-approximation sequencer driven by the conversion clock tick.
// Assumes cmp_above is high while the input is at or above trial_code.
`timescale 1ns/1ns
`include "acc_map.svh"
module acc_sar
  import acc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       eight_bit,
  input  wire logic       cmp_above,
  output logic            busy,
  output logic            hold,
  output logic [9:0]      trial_code,
  output logic [9:0]      code
);
  acc_sar_state_t state;
  logic [1:0]     hold_cnt;
  logic [9:0]     probe;
  logic           mode8;
  wire  [9:0]     stop_probe = mode8 ? `ACC_STOP_EIGHT : `ACC_STOP_TEN;
  wire  [9:0]     kept = cmp_above ? trial_code : (trial_code & ~probe);

  // Two hold ticks, one tick per bit, one finish tick: 13 or 11 in all.
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= ACC_IDLE;
      busy       <= 1'b0;
      hold       <= 1'b0;
      hold_cnt   <= 2'h0;
      probe      <= 10'h000;
      mode8      <= 1'b0;
      trial_code <= 10'h000;
      code       <= 10'h000;
    end else begin
      unique case (state)
        ACC_IDLE: if (start) begin
          state      <= ACC_HOLD;
          busy       <= 1'b1;
          hold       <= 1'b1;
          hold_cnt   <= 2'h0;
          mode8      <= eight_bit;
          trial_code <= 10'h000;
        end
        ACC_HOLD: if (tick) begin
          hold_cnt <= hold_cnt + 2'h1;
          if (hold_cnt == `ACC_HOLD_TICKS - 2'h1) begin
            state      <= ACC_BITS;
            hold       <= 1'b0;
            probe      <= `ACC_PROBE_TOP;
            trial_code <= `ACC_PROBE_TOP;
          end
        end
        ACC_BITS: if (tick) begin
          trial_code <= kept | (probe == stop_probe ? 10'h000 : (probe >> 1));
          probe      <= probe >> 1;
          if (probe == stop_probe) begin
            state <= ACC_FINISH;
          end
        end
        ACC_FINISH: if (tick) begin
          state <= ACC_IDLE;
          busy  <= 1'b0;
          code  <= mode8 ? {2'b00, trial_code[9:2]} : trial_code;
        end
      endcase
    end
  end
endmodule

// ===== rtl/acc_top.sv
// Conversion control: Wishbone registers, conversion clock divider, start
// source selection, result formatting, window compare and interrupt.
// Assumes timer overflow inputs are one-cycle pulses on clk and the
// comparator output is valid on clk; the start pin is asynchronous.
`timescale 1ns/1ns
`include "acc_map.svh"
module acc_top
  import acc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        timer0_overflow,
  input  wire logic        timer1_overflow,
  input  wire logic        timer2_low_overflow,
  input  wire logic        timer2_high_overflow,
  input  wire logic        timer3_low_overflow,
  input  wire logic        timer3_high_overflow,
  input  wire logic        external_start_pin,
  input  wire logic        cmp_above,
  output logic [9:0]       trial_code,
  output logic             track_hold,
  output logic             irq
);

  // --------------------------------------------------------------------------
  // Byte-lane merge used by every writable register
  // --------------------------------------------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [2:0]  start_source_select;
  logic        timer2_16bit;
  logic        timer3_16bit;
  logic        justify_select;
  logic        eight_bit_mode_enable;
  logic [4:0]  conv_clock_divider;
  logic [15:0] greater_than_bound;
  logic [15:0] less_than_bound;
  logic [15:0] result_word;
  logic        conversion_done_flag;
  logic        window_compare_flag;
  logic [1:0]  irq_mask;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire bus_req  = wb_cyc_i && wb_stb_i;
  wire bus_wr   = bus_req && wb_we_i && wb_ack_o;
  wire sel_ctl  = wb_adr_i == `ACC_OFS_CONTROL;
  wire sel_cfg  = wb_adr_i == `ACC_OFS_CONFIG;
  wire sel_res  = wb_adr_i == `ACC_OFS_RESULT;
  wire sel_gt   = wb_adr_i == `ACC_OFS_GT_BOUND;
  wire sel_lt   = wb_adr_i == `ACC_OFS_LT_BOUND;
  wire sel_st   = wb_adr_i == `ACC_OFS_STATUS;
  wire sel_mask = wb_adr_i == `ACC_OFS_MASK;

  logic        conversion_busy;
  logic [9:0]  sar_code;

  wire [31:0] ctl_view = {26'h0, timer3_16bit, timer2_16bit,
                          conversion_busy, start_source_select};
  wire [31:0] cfg_view = {24'h0, conv_clock_divider, 1'b0,
                          eight_bit_mode_enable, justify_select};
  wire [31:0] st_view  = {30'h0, window_compare_flag, conversion_done_flag};
  wire [31:0] ctl_new  = lane_merge(ctl_view, wb_dat_i, wb_sel_i);
  wire [31:0] cfg_new  = lane_merge(cfg_view, wb_dat_i, wb_sel_i);
  wire [31:0] gt_new   = lane_merge({16'h0, greater_than_bound}, wb_dat_i, wb_sel_i);
  wire [31:0] lt_new   = lane_merge({16'h0, less_than_bound}, wb_dat_i, wb_sel_i);
  wire [31:0] st_new   = lane_merge(st_view, wb_dat_i, wb_sel_i);
  wire [31:0] mask_new = lane_merge({30'h0, irq_mask}, wb_dat_i, wb_sel_i);

  // Unmapped offsets read as zero and still acknowledge.
  wire [31:0] read_mux =
      sel_ctl  ? ctl_view :
      sel_cfg  ? cfg_view :
      sel_res  ? {16'h0, result_word} :
      sel_gt   ? {16'h0, greater_than_bound} :
      sel_lt   ? {16'h0, less_than_bound} :
      sel_st   ? st_view :
      sel_mask ? {30'h0, irq_mask} : 32'h0000_0000;

  // --------------------------------------------------------------------------
  // Wishbone answer
  // --------------------------------------------------------------------------
  // Ack rises one cycle after the request and the write lands on the edge
  // where the master samples ack; a request held past ack is acked and written again every other cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= read_mux;
    end
  end

  // --------------------------------------------------------------------------
  // Control and configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      start_source_select   <= 3'h0;
      timer2_16bit          <= 1'b0;
      timer3_16bit          <= 1'b0;
      justify_select        <= 1'b0;
      eight_bit_mode_enable <= 1'b0;
      conv_clock_divider    <= `ACC_DIV_RESET;
      greater_than_bound    <= 16'h0000;
      less_than_bound       <= 16'h0000;
      irq_mask              <= 2'h0;
    end else begin
      if (bus_wr && sel_ctl) begin
        start_source_select <= ctl_new[`ACC_CTL_SRC_LSB +: 3];
        timer2_16bit        <= ctl_new[`ACC_CTL_T2_16];
        timer3_16bit        <= ctl_new[`ACC_CTL_T3_16];
      end
      if (bus_wr && sel_cfg) begin
        justify_select        <= cfg_new[`ACC_CFG_JUSTIFY];
        eight_bit_mode_enable <= cfg_new[`ACC_CFG_EIGHT];
        conv_clock_divider    <= cfg_new[`ACC_CFG_DIV_LSB +: 5];
      end
      if (bus_wr && sel_gt) begin
        greater_than_bound <= gt_new[15:0];
      end
      if (bus_wr && sel_lt) begin
        less_than_bound <= lt_new[15:0];
      end
      if (bus_wr && sel_mask) begin
        irq_mask <= mask_new[1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Conversion clock divider
  // --------------------------------------------------------------------------
  // The tick marks one conversion clock every divider+1 system clocks.
  logic [4:0] div_count;
  logic       conv_tick;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_count <= 5'h00;
      conv_tick <= 1'b0;
    end else begin
      div_count <= (div_count >= conv_clock_divider) ? 5'h00 : div_count + 5'h01;
      conv_tick <= div_count >= conv_clock_divider;
    end
  end

  // --------------------------------------------------------------------------
  // Start source selection
  // --------------------------------------------------------------------------
  logic ext_rise;

  acc_sync u_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (external_start_pin),
    .level (),
    .rise  (ext_rise)
  );

  wire sw_start  = bus_wr && sel_ctl && ctl_new[`ACC_CTL_BUSY];
  wire t2_event  = timer2_16bit ? timer2_high_overflow : timer2_low_overflow;
  wire t3_event  = timer3_16bit ? timer3_high_overflow : timer3_low_overflow;
  wire [2:0] src = start_source_select;
  // Codes six and seven select no trigger at all.
  wire trigger =
      (src == ACC_SRC_SOFTWARE) ? sw_start :
      (src == ACC_SRC_TIMER0)   ? timer0_overflow :
      (src == ACC_SRC_TIMER2)   ? t2_event :
      (src == ACC_SRC_TIMER1)   ? timer1_overflow :
      (src == ACC_SRC_EXTERNAL) ? ext_rise :
      (src == ACC_SRC_TIMER3)   ? t3_event : 1'b0;

  // A trigger that arrives during a conversion is dropped by the sequencer.
  acc_sar u_sar (
    .clk        (clk),
    .rst        (rst),
    .tick       (conv_tick),
    .start      (trigger),
    .eight_bit  (eight_bit_mode_enable),
    .cmp_above  (cmp_above),
    .busy       (conversion_busy),
    .hold       (track_hold),
    .trial_code (trial_code),
    .code       (sar_code)
  );

  // --------------------------------------------------------------------------
  // Result formatting and window compare
  // --------------------------------------------------------------------------
  logic busy_prev;
  logic eight_at_start;
  wire  busy_fall = busy_prev && !conversion_busy;

  // Eight-bit placement follows the mode captured at start; the justify
  // select is read live, so a mid-conversion change to it moves the bits.
  wire [15:0] fmt_word =
      eight_at_start ? {sar_code[7:0], 8'h00} :
      justify_select ? {sar_code, 6'h00} :
                       {6'h00, sar_code};

  wire window_inside = less_than_bound > greater_than_bound;
  wire in_range  = (fmt_word > greater_than_bound) && (fmt_word < less_than_bound);
  wire out_range = (fmt_word < greater_than_bound) || (fmt_word > less_than_bound);
  wire window_hit = window_inside ? in_range : out_range;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_prev      <= 1'b0;
      eight_at_start <= 1'b0;
      result_word    <= 16'h0000;
    end else begin
      busy_prev <= conversion_busy;
      if (trigger && !conversion_busy) begin
        eight_at_start <= eight_bit_mode_enable;
      end
      if (busy_fall) begin
        result_word <= fmt_word;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status flags and interrupt
  // --------------------------------------------------------------------------
  // Writing zero clears a flag; a set in the same cycle wins.
  wire done_clear = bus_wr && sel_st && !st_new[`ACC_ST_DONE];
  wire win_clear  = bus_wr && sel_st && !st_new[`ACC_ST_WINDOW];

  always_ff @(posedge clk) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
      window_compare_flag  <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      conversion_done_flag <= busy_fall || (conversion_done_flag && !done_clear);
      window_compare_flag  <= (busy_fall && window_hit) ||
                              (window_compare_flag && !win_clear);
      irq <= |({window_compare_flag, conversion_done_flag} & irq_mask);
    end
  end

endmodule

// ===== bench/acc_checker_sva.sv
// Concurrent checks on the ports of the conversion control block.
// Assumes one clock domain, a synchronous active-high reset and a bind to acc_top.
`timescale 1ns/1ns
module acc_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [9:0]  trial_code,
  input wire logic        track_hold,
  input wire logic        irq
);
  // ---------------------------------------------------------------------------
  // Bus, reset and conversion properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  logic sw_start;
  logic result_read;
  assign sw_start = wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]
                    && wb_dat_i[3] && wb_dat_i[2:0] == 3'h0;
  assign result_read = wb_ack_o && !wb_we_i && wb_adr_i == 8'h08;

  property p_ack_follows;
    disable iff (rst) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack missing after request");
  property p_ack_pulse;
    disable iff (rst) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    disable iff (rst) wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_reset_quiet;
    rst |=> !wb_ack_o && !irq && !track_hold && trial_code == 10'h000;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  property p_hold_min;
    disable iff (rst) $rose(track_hold) |-> track_hold[*2];
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("hold phase too short");
  property p_hold_max;
    disable iff (rst) $rose(track_hold) |-> ##[1:100] !track_hold;
  endproperty
  a_hold_max: assert property (p_hold_max) else $error("hold phase too long");
  property p_result_zero;
    disable iff (rst) result_read |-> wb_dat_o[31:16] == 16'h0000
      && (wb_dat_o[15:10] == 6'h00 || wb_dat_o[5:0] == 6'h00);
  endproperty
  a_result_zero: assert property (p_result_zero) else $error("unused result bits set");
  property p_sw_start;
    disable iff (rst) sw_start |-> ##[1:4] track_hold;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start ignored");

  c_hold: cover property (disable iff (rst) $rose(track_hold));
  c_irq: cover property (disable iff (rst) $rose(irq));
  c_result: cover property (disable iff (rst) result_read);
endmodule

bind acc_top acc_checker chk (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .trial_code(trial_code), .track_hold(track_hold), .irq(irq)
);

// ===== bench/acc_analog_model.sv
// Ideal comparator standing in for the analog input and reference.
// Assumes the level is a ground-referenced unsigned code on the trial scale.
`timescale 1ns/1ns
module acc_analog_model (
  input  wire logic [9:0] trial_code,
  input  wire logic [9:0] level,
  output logic            cmp_above
);
  assign cmp_above = level >= trial_code;
endmodule

// ===== bench/adc_conversion_control_test.sv
// Self-checking bench: Wishbone tasks, timer and pin stimulus, reference model.
// Assumes acc_top, acc_analog_model and the bound checker are compiled first.
`timescale 1ns/1ns
module adc_conversion_control_test;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic [6:0]  trig;
  logic [9:0]  level;
  logic [9:0]  trial;
  logic        cmp;
  logic        hold;
  logic        irq;
  int          errors;
  int          comparisons;
  int          seed;
  int          vin;
  int          cfg;
  int          gt;
  int          lt;
  int          msk;
  int          d;
  int          k;
  int          tc[7] = '{1, 3, 2, 18, 5, 37, 4};
  int          tw[7] = '{1, 0, 3, 2, 5, 4, 0};

  always #20 clk = ~clk;

  acc_top dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer0_overflow(trig[0]), .timer1_overflow(trig[1]), .timer2_low_overflow(trig[2]),
    .timer2_high_overflow(trig[3]), .timer3_low_overflow(trig[4]),
    .timer3_high_overflow(trig[5]), .external_start_pin(trig[6]), .cmp_above(cmp),
    .trial_code(trial), .track_hold(hold), .irq(irq)
  );
  acc_analog_model far (.trial_code(trial), .level(level), .cmp_above(cmp));

  // ---------------------------------------------------------------------------
  // Reference model and tasks
  // ---------------------------------------------------------------------------
  function automatic int fmt();
    if (cfg & 2) return (vin >> 2) << 8;
    return (cfg & 1) ? vin << 6 : vin;
  endfunction

  function automatic int win(input int r);
    return (lt > gt) ? int'(r > gt && r < lt) : int'(r < gt || r > lt);
  endfunction

  task automatic complete_run;
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input int dv, input logic [3:0] s);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dv;
    sel <= s;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (t >= 20) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    trig[b] <= 1'b1;
    repeat (b == 6 ? 10 : 1) @(posedge clk);
    trig[b] <= 1'b0;
  endtask

  // Without the interrupt, completion is found by polling the done flag.
  task automatic wait_done(input int timed);
    int t;
    t = 0;
    d = 0;
    while (timed && hold !== 1'b1 && t < 200) begin
      @(posedge clk);
      t++;
    end
    while (msk && irq !== 1'b1 && d < 3000) begin
      @(posedge clk);
      d++;
    end
    while (!msk && d < 3000) begin
      bus(0, 8'h14, 0, 4'hF);
      d++;
      if (q[0] === 1'b1) break;
    end
    if (t >= 200 || d >= 3000) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic conv_end(input int timed, input int ctl);
    int n;
    int p;
    n = (cfg & 2) ? 11 : 13;
    p = ((cfg >> 3) & 31) + 1;
    wait_done(timed);
    if (timed) check("conv_cycles", 1, d >= n * p - p + 1 && d <= n * p + 3);
    bus(0, 8'h14, 0, 4'hF);
    check("status", win(fmt()) * 2 + 1, q);
    bus(0, 8'h08, 0, 4'hF);
    check("result", fmt(), q);
    bus(0, 8'h00, 0, 4'hF);
    check("control", ctl, q);
    check("irq", msk, {31'h0, irq});
    bus(1, 8'h14, 3, 4'h1);
    bus(0, 8'h14, 0, 4'hF);
    check("status_kept", win(fmt()) * 2 + 1, q);
    bus(1, 8'h14, 0, 4'h1);
    bus(0, 8'h14, 0, 4'hF);
    check("status_clear", 0, q);
    check("irq_clear", 0, {31'h0, irq});
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, adr, sel, wdat, trig, level} = '0;
    {errors, comparisons, vin, cfg, gt, lt, msk} = '0;
    seed = 19426;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 8; k++) begin
      bus(0, 8'(k * 4), 0, 4'hF);
      check("reset_value", k == 1 ? 32'h0000_0018 : 32'h0000_0000, q);
    end
    for (k = 0; k < 8; k++) begin
      vin = $random(seed) & 1023;
      cfg = ((k >> 1) << 3) | (k & 3);
      gt = $random(seed) & 65535;
      lt = (k == 0) ? gt : $random(seed) & 65535;
      if (k & 1) begin
        gt = (fmt() + 65535) & 65535;
        lt = fmt() + (k & 2);
      end
      level <= 10'(vin);
      msk = (k != 7);
      bus(1, 8'h18, msk, 4'hF);
      bus(1, 8'h04, cfg, 4'hF);
      bus(1, 8'h0C, gt, 4'hF);
      bus(1, 8'h10, lt, 4'hF);
      bus(1, 8'h00, 8, 4'h1);
      conv_end(msk, 0);
    end
    cfg = 24;
    msk = 1;
    bus(1, 8'h04, cfg, 4'hF);
    bus(1, 8'h18, msk, 4'hF);
    for (k = 0; k < 7; k++) begin
      vin = $random(seed) & 1023;
      level <= 10'(vin);
      bus(1, 8'h00, tc[k], 4'h1);
      pulse(tw[k]);
      repeat (12) @(posedge clk);
      bus(0, 8'h00, 0, 4'hF);
      check("ignored_trigger", tc[k], q);
      pulse(k == 6 ? 6 : tc[k] == 3 ? 1 : tc[k] == 1 ? 0 : tw[k] ^ 1);
      bus(0, 8'h00, 0, 4'hF);
      check("busy", tc[k] | 8, q);
      conv_end(0, tc[k]);
    end
    complete_run();
  end
endmodule
